// ---- hw/sbtc_timer.sv ----
// sbtc_timer: sixteen-bit timer/counter with input capture, two compare
// channels, prescaler and external count pin, behind an 8-bit register port.
// assumes a 40 MHz CLK_IN, a synchronous reset and a single-cycle bus master.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module sbtc_timer (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       CAPTURE_INPUT_IN,
  input  wire logic       COMPARATOR_IN,
  input  wire logic       COUNT_PIN_IN,
  input  wire logic       GLOBAL_IRQ_EN_IN,
  input  wire logic       ACK_OVF_IN,
  input  wire logic       ACK_CMP_A_IN,
  input  wire logic       ACK_CMP_B_IN,
  input  wire logic       ACK_CAP_IN,
  output logic            IRQ_OVF_OUT,
  output logic            IRQ_CMP_A_OUT,
  output logic            IRQ_CMP_B_OUT,
  output logic            IRQ_CAP_OUT,
  output logic            WAVE_OUT_A_OUT,
  output logic            WAVE_OUT_B_OUT
);
  // ==========================================================
  // declarations
  logic [7:0]  ctl_b_q;
  logic [7:0]  wave_ctl_q;
  logic [7:0]  mask_q;
  logic [7:0]  misc_q;
  logic [7:0]  temp_q;
  logic        ovf_flag_q;
  logic        cmp_a_flag_q;
  logic        cmp_b_flag_q;
  logic        cap_flag_q;
  logic [15:0] cnt_q;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] cap_q;
  logic [sbtc_pkg::PRESCALE_W-1:0] pre_q;
  logic [sbtc_pkg::PRESCALE_W-1:0] pre_nx;
  logic [1:0]  cnt_pin_sync_q;
  logic [1:0]  cap_pin_sync_q;
  logic        cnt_pin_prev_q;
  logic        block_q;
  logic        wave_a_q;
  logic        wave_b_q;
  logic [7:0]  rdata_q;
  logic [3:0]  wgm;
  logic [2:0]  cs;
  logic        tick;
  logic        pwm_mode;
  logic        cap_is_top;
  logic        cap_src;
  logic        cap_edge;
  logic        cap_event;
  logic [15:0] top;
  logic        at_top;
  logic        match_a;
  logic        match_b;
  logic        ovf_ev;
  logic        clear_cnt;
  logic        cnt_wr;
  logic        force_a;
  logic        force_b;
  logic        wr;
  logic        wr_force;

  assign wgm      = {ctl_b_q[sbtc_pkg::BIT_WGM_HI+1:sbtc_pkg::BIT_WGM_HI], wave_ctl_q[1:0]};
  assign cs       = ctl_b_q[2:0];
  assign wr       = WR_IN;
  assign cnt_wr   = wr && (ADDR_IN == sbtc_pkg::ADDR_CNT_LO);
  assign wr_force = wr && (ADDR_IN == sbtc_pkg::ADDR_FORCE);

  // pwm: all modes except normal, the two clear-on-compare modes and reserved
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == sbtc_pkg::WGM_NORMAL || m == sbtc_pkg::WGM_CTC_A ||
               m == sbtc_pkg::WGM_CTC_CAP || m == sbtc_pkg::WGM_RESERVED);
  endfunction : is_pwm

  // compare output action for a match: toggle, clear or set
  function automatic logic wave_next(input logic [1:0] com, input logic cur);
    case (com)
      2'h1:    wave_next = ~cur;
      2'h2:    wave_next = 1'b0;
      2'h3:    wave_next = 1'b1;
      default: wave_next = cur;
    endcase
  endfunction : wave_next

  assign pwm_mode = is_pwm(wgm);
  // capture used as top: the pin is cut off and the flag marks top instead
  assign cap_is_top = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == sbtc_pkg::WGM_CTC_CAP) || (wgm == 4'hE);

  // ==========================================================
  // top selection
  always_comb begin
    case (wgm)
      4'h1, 4'h5:                 top = sbtc_pkg::TOP_8BIT;
      4'h2, 4'h6:                 top = sbtc_pkg::TOP_9BIT;
      4'h3, 4'h7:                 top = sbtc_pkg::TOP_10BIT;
      sbtc_pkg::WGM_CTC_A, 4'h9, 4'hB, 4'hF: top = cmp_a_q;
      sbtc_pkg::WGM_CTC_CAP, 4'h8, 4'hA, 4'hE: top = cap_q;
      default:                    top = sbtc_pkg::TOP_MAX;
    endcase
  end

  // ==========================================================
  // prescaler and clock source; free running, shared taps
  assign pre_nx = pre_q + 1'b1;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      pre_q <= '0;
    else
      pre_q <= pre_nx;
  end

  function automatic logic tap_hit(input logic [sbtc_pkg::PRESCALE_W-1:0] p, input int n);
    logic [sbtc_pkg::PRESCALE_W-1:0] m;
    m = sbtc_pkg::PRESCALE_W'((1 << n) - 1);
    tap_hit = ((p & m) == m);
  endfunction : tap_hit

  // the count pin is sampled regardless of its direction, so software may drive it
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cnt_pin_sync_q <= 2'h0;
      cnt_pin_prev_q <= 1'b0;
    end else begin
      cnt_pin_sync_q <= {cnt_pin_sync_q[0], COUNT_PIN_IN};
      cnt_pin_prev_q <= cnt_pin_sync_q[1];
    end
  end

  // external edges lag the pin by about three clocks through sync and edge detect
  always_comb begin
    case (cs)
      sbtc_pkg::CS_STOP:     tick = 1'b0;
      sbtc_pkg::CS_DIV1:     tick = 1'b1;
      sbtc_pkg::CS_DIV8:     tick = tap_hit(pre_q, sbtc_pkg::TAP_DIV8);
      sbtc_pkg::CS_DIV64:    tick = tap_hit(pre_q, sbtc_pkg::TAP_DIV64);
      sbtc_pkg::CS_DIV256:   tick = tap_hit(pre_q, sbtc_pkg::TAP_DIV256);
      sbtc_pkg::CS_DIV1024:  tick = tap_hit(pre_q, sbtc_pkg::TAP_DIV1024);
      sbtc_pkg::CS_EXT_FALL: tick = cnt_pin_prev_q & ~cnt_pin_sync_q[1];
      sbtc_pkg::CS_EXT_RISE: tick = ~cnt_pin_prev_q & cnt_pin_sync_q[1];
      default:               tick = 1'b0;
    endcase
  end

  // ==========================================================
  // counter and compare events
  assign at_top    = (cnt_q == top);
  assign match_a   = tick && !block_q && (cnt_q == cmp_a_q);
  assign match_b   = tick && !block_q && (cnt_q == cmp_b_q);
  assign clear_cnt = (wgm == sbtc_pkg::WGM_CTC_A || wgm == sbtc_pkg::WGM_CTC_CAP) && at_top;
  assign ovf_ev    = tick && (cnt_q == sbtc_pkg::TOP_MAX);
  // a forced strobe only moves the outputs; flags and the clear see real matches
  assign force_a   = wr_force && WDATA_IN[sbtc_pkg::BIT_FORCE_A] && !pwm_mode;
  assign force_b   = wr_force && WDATA_IN[sbtc_pkg::BIT_FORCE_B] && !pwm_mode;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      cnt_q <= '0;
    else if (cnt_wr)
      cnt_q <= {temp_q, WDATA_IN};
    else if (tick)
      cnt_q <= clear_cnt ? 16'h0000 : cnt_q + 16'h0001;
  end

  // write to counter blocks the match on the following timer clock
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      block_q <= 1'b0;
    else if (cnt_wr)
      block_q <= 1'b1;
    else if (tick)
      block_q <= 1'b0;
  end

  // ==========================================================
  // capture
  assign cap_src = misc_q[sbtc_pkg::BIT_CAP_SRC] ? COMPARATOR_IN : cap_pin_sync_q[1];
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      cap_pin_sync_q <= 2'h0;
    else
      cap_pin_sync_q <= {cap_pin_sync_q[0], CAPTURE_INPUT_IN};
  end

  sbtc_capture_filter u_filter (
    .clk_in       (CLK_IN),
    .rst_in       (RST_IN),
    .sample_in    (cap_src),
    .filter_en_in (ctl_b_q[sbtc_pkg::BIT_NOISE_EN]),
    .rise_sel_in  (ctl_b_q[sbtc_pkg::BIT_EDGE_SEL]),
    .edge_out     (cap_edge)
  );

  assign cap_event = cap_edge && !cap_is_top;

  // ==========================================================
  // register writes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctl_b_q    <= sbtc_pkg::RESET_BYTE;
      wave_ctl_q <= sbtc_pkg::RESET_BYTE;
      mask_q     <= sbtc_pkg::RESET_BYTE;
      misc_q     <= sbtc_pkg::RESET_BYTE;
      temp_q     <= sbtc_pkg::RESET_BYTE;
      cmp_a_q    <= '0;
      cmp_b_q    <= '0;
    end else if (wr) begin
      case (ADDR_IN)
        sbtc_pkg::ADDR_CLK_CAP:   ctl_b_q <= WDATA_IN & sbtc_pkg::MASK_CLK_CAP;
        sbtc_pkg::ADDR_WAVE_CTRL: wave_ctl_q <= WDATA_IN & sbtc_pkg::MASK_WAVE_CTRL;
        sbtc_pkg::ADDR_IRQ_MASK:  mask_q <= WDATA_IN & sbtc_pkg::MASK_IRQ_MASK;
        sbtc_pkg::ADDR_MISC:      misc_q <= {7'h00, WDATA_IN[sbtc_pkg::BIT_CAP_SRC]};
        sbtc_pkg::ADDR_CNT_HI, sbtc_pkg::ADDR_CMP_A_HI,
        sbtc_pkg::ADDR_CMP_B_HI, sbtc_pkg::ADDR_CAP_HI: temp_q <= WDATA_IN;
        sbtc_pkg::ADDR_CMP_A_LO:  cmp_a_q <= {temp_q, WDATA_IN};
        sbtc_pkg::ADDR_CMP_B_LO:  cmp_b_q <= {temp_q, WDATA_IN};
        default: ;
      endcase
    end else if (RD_IN) begin
      // low byte read latches the high byte for a later atomic read
      case (ADDR_IN)
        sbtc_pkg::ADDR_CNT_LO: temp_q <= cnt_q[15:8];
        sbtc_pkg::ADDR_CAP_LO: temp_q <= cap_q[15:8];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      cap_q <= '0;
    else if (cap_event)
      cap_q <= cnt_q;
    else if (wr && ADDR_IN == sbtc_pkg::ADDR_CAP_LO)
      cap_q <= {temp_q, WDATA_IN};
  end

  // ==========================================================
  // flags: hardware set wins over clear
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction : flag_next

  logic wr_flags;
  assign wr_flags = wr && (ADDR_IN == sbtc_pkg::ADDR_FLAGS);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ovf_flag_q   <= 1'b0;
      cmp_a_flag_q <= 1'b0;
      cmp_b_flag_q <= 1'b0;
      cap_flag_q   <= 1'b0;
    end else begin
      ovf_flag_q   <= flag_next(ovf_flag_q, ovf_ev,
                       ACK_OVF_IN | (wr_flags & WDATA_IN[sbtc_pkg::BIT_OVF]));
      cmp_a_flag_q <= flag_next(cmp_a_flag_q, match_a,
                       ACK_CMP_A_IN | (wr_flags & WDATA_IN[sbtc_pkg::BIT_CMP_A]));
      cmp_b_flag_q <= flag_next(cmp_b_flag_q, match_b,
                       ACK_CMP_B_IN | (wr_flags & WDATA_IN[sbtc_pkg::BIT_CMP_B]));
      cap_flag_q   <= flag_next(cap_flag_q, cap_event | (tick & cap_is_top & at_top),
                       ACK_CAP_IN | (wr_flags & WDATA_IN[sbtc_pkg::BIT_CAP]));
    end
  end

  // ==========================================================
  // waveform outputs (non-PWM behaviour only)
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else begin
      if (match_a || force_a)
        wave_a_q <= wave_next(wave_ctl_q[sbtc_pkg::BIT_COM_A+:2], wave_a_q);
      if (match_b || force_b)
        wave_b_q <= wave_next(wave_ctl_q[sbtc_pkg::BIT_COM_B+:2], wave_b_q);
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN)
      rdata_q <= 8'h00;
    else if (RD_IN) begin
      case (ADDR_IN)
        sbtc_pkg::ADDR_CLK_CAP:   rdata_q <= ctl_b_q;
        sbtc_pkg::ADDR_WAVE_CTRL: rdata_q <= wave_ctl_q;
        sbtc_pkg::ADDR_IRQ_MASK:  rdata_q <= mask_q;
        sbtc_pkg::ADDR_MISC:      rdata_q <= misc_q;
        sbtc_pkg::ADDR_FLAGS:     rdata_q <= {ovf_flag_q, cmp_b_flag_q, cmp_a_flag_q, 1'b0, cap_flag_q, 3'h0};
        sbtc_pkg::ADDR_FORCE:     rdata_q <= 8'h00;
        sbtc_pkg::ADDR_CNT_LO:    rdata_q <= cnt_q[7:0];
        sbtc_pkg::ADDR_CAP_LO:    rdata_q <= cap_q[7:0];
        sbtc_pkg::ADDR_CMP_A_LO:  rdata_q <= cmp_a_q[7:0];
        sbtc_pkg::ADDR_CMP_B_LO:  rdata_q <= cmp_b_q[7:0];
        sbtc_pkg::ADDR_CMP_A_HI:  rdata_q <= cmp_a_q[15:8];
        sbtc_pkg::ADDR_CMP_B_HI:  rdata_q <= cmp_b_q[15:8];
        // counter and capture high bytes come from the copy taken at the low-byte read, so a pair is atomic
        sbtc_pkg::ADDR_CNT_HI, sbtc_pkg::ADDR_CAP_HI: rdata_q <= temp_q;
        default:                  rdata_q <= 8'h00;
      endcase
    end else
      rdata_q <= 8'h00;
  end

  assign RDATA_OUT      = rdata_q;
  assign IRQ_OVF_OUT    = mask_q[sbtc_pkg::BIT_OVF] & GLOBAL_IRQ_EN_IN & ovf_flag_q;
  assign IRQ_CMP_A_OUT  = mask_q[sbtc_pkg::BIT_CMP_A] & GLOBAL_IRQ_EN_IN & cmp_a_flag_q;
  assign IRQ_CMP_B_OUT  = mask_q[sbtc_pkg::BIT_CMP_B] & GLOBAL_IRQ_EN_IN & cmp_b_flag_q;
  assign IRQ_CAP_OUT    = mask_q[sbtc_pkg::BIT_CAP] & GLOBAL_IRQ_EN_IN & cap_flag_q;
  assign WAVE_OUT_A_OUT = wave_a_q;
  assign WAVE_OUT_B_OUT = wave_b_q;
endmodule : sbtc_timer

// ---- hw/sbtc_pkg.sv ----
// sbtc_pkg: register offsets, field positions, reset values and timing counts
// for the sixteen-bit timer with capture; shared by the core and its helper.
package sbtc_pkg;
  // register addresses (8-bit data, 8-bit address space)
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h3A;
  localparam logic [7:0] ADDR_FLAGS        = 8'h39;
  localparam logic [7:0] ADDR_CMP_B_LO     = 8'h6A;
  localparam logic [7:0] ADDR_CMP_B_HI     = 8'h6B;
  localparam logic [7:0] ADDR_CNT_LO       = 8'h6C;
  localparam logic [7:0] ADDR_CNT_HI       = 8'h6D;
  localparam logic [7:0] ADDR_CMP_A_LO     = 8'h6E;
  localparam logic [7:0] ADDR_CMP_A_HI     = 8'h6F;
  localparam logic [7:0] ADDR_FORCE        = 8'h70;
  localparam logic [7:0] ADDR_CLK_CAP      = 8'h71;
  localparam logic [7:0] ADDR_WAVE_CTRL    = 8'h72;
  localparam logic [7:0] ADDR_CAP_LO       = 8'h74;
  localparam logic [7:0] ADDR_CAP_HI       = 8'h75;
  localparam logic [7:0] ADDR_MISC         = 8'h76;
  // field positions
  localparam int BIT_NOISE_EN    = 7;
  localparam int BIT_EDGE_SEL    = 6;
  localparam int BIT_WGM_HI      = 3;
  localparam int BIT_FORCE_A     = 7;
  localparam int BIT_FORCE_B     = 6;
  localparam int BIT_OVF         = 7;
  localparam int BIT_CMP_A       = 6;
  localparam int BIT_CMP_B       = 5;
  localparam int BIT_CAP         = 3;
  localparam int BIT_COM_A       = 6;
  localparam int BIT_COM_B       = 4;
  localparam int BIT_CAP_SRC     = 0;
  // writable masks (reserved bits read as zero)
  localparam logic [7:0] MASK_CLK_CAP    = 8'hDF;
  localparam logic [7:0] MASK_IRQ_MASK   = 8'hE8;
  localparam logic [7:0] MASK_FLAGS      = 8'hE8;
  localparam logic [7:0] MASK_WAVE_CTRL  = 8'hF3;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler tap positions (divide by 2**n)
  localparam int TAP_DIV8 = 3;
  localparam int TAP_DIV64 = 6;
  localparam int TAP_DIV256 = 8;
  localparam int TAP_DIV1024 = 10;
  localparam int PRESCALE_W = 10;
  // waveform modes
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_A    = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
  localparam logic [3:0] WGM_RESERVED = 4'hD;
  localparam logic [15:0] TOP_MAX     = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
  // noise filter length in samples
  localparam int FILTER_SAMPLES = 4;
endpackage : sbtc_pkg

// ---- hw/sbtc_capture_filter.sv ----
// sbtc_capture_filter: optional majority-free noise filter and edge detect.
// assumes the input is already synchronised to CLK_IN.
`timescale 1ns/1ps
module sbtc_capture_filter #(
  parameter int SAMPLES = sbtc_pkg::FILTER_SAMPLES
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic sample_in,
  input  wire logic filter_en_in,
  input  wire logic rise_sel_in,
  output logic      edge_out
);
  logic [SAMPLES-1:0] hist_q;
  logic               filt_q;
  logic               prev_q;
  logic               level;

  // ==========================================================
  // filter: output flips only after SAMPLES equal samples
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[SAMPLES-2:0], sample_in};
      if (&hist_q)
        filt_q <= 1'b1;
      else if (~|hist_q)
        filt_q <= 1'b0;
    end
  end

  assign level = filter_en_in ? filt_q : sample_in;

  // ==========================================================
  // edge detect
  always_ff @(posedge clk_in) begin
    if (rst_in)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  // zero picks the falling edge, one the rising edge
  assign edge_out = rise_sel_in ? (level & ~prev_q) : (~level & prev_q);
endmodule : sbtc_capture_filter

// ---- bench/sbtc_timer_monitor.sv ----
// sbtc_timer_monitor: port-level assertions for the sixteen-bit timer.
// assumes it is bound to sbtc_timer and sees a single-cycle register port.
`timescale 1ns/1ps
module sbtc_timer_monitor (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       GLOBAL_IRQ_EN_IN,
  input wire logic       IRQ_OVF_OUT,
  input wire logic       IRQ_CMP_A_OUT,
  input wire logic       IRQ_CMP_B_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ==========================================================
  // shadow of mask and clock select, seen from bus writes
  logic [7:0] mask_q;
  logic [2:0] cs_q;
  logic [1:0] stop_age_q;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) mask_q <= 8'h00;
    else if (WR_IN && ADDR_IN == sbtc_pkg::ADDR_IRQ_MASK) mask_q <= WDATA_IN;
  end
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) cs_q <= 3'h0;
    else if (WR_IN && ADDR_IN == sbtc_pkg::ADDR_CLK_CAP) cs_q <= WDATA_IN[2:0];
  end
  // pending ticks may still land just after a stop, so wait three cycles
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || cs_q != sbtc_pkg::CS_STOP) stop_age_q <= 2'h0;
    else if (stop_age_q != 2'h3) stop_age_q <= stop_age_q + 2'h1;
  end
  // ==========================================================
  // assertions
  ovf_irq_gate_a: assert property (IRQ_OVF_OUT |-> GLOBAL_IRQ_EN_IN && mask_q[7])
    else $error("overflow request without enable");
  cmpa_irq_gate_a: assert property (IRQ_CMP_A_OUT |-> GLOBAL_IRQ_EN_IN && mask_q[6])
    else $error("compare A request without enable");
  cmpb_irq_gate_a: assert property (IRQ_CMP_B_OUT |-> GLOBAL_IRQ_EN_IN && mask_q[5])
    else $error("compare B request without enable");
  force_reads_zero_a: assert property ($past(RD_IN) && $past(ADDR_IN) == sbtc_pkg::ADDR_FORCE
    |-> RDATA_OUT == 8'h00) else $error("force register read not zero");
  clkctl_reserved_a: assert property ($past(RD_IN) && $past(ADDR_IN) == sbtc_pkg::ADDR_CLK_CAP
    |-> RDATA_OUT[5] == 1'b0) else $error("clock control reserved bit set");
  mask_reserved_a: assert property ($past(RD_IN) && $past(ADDR_IN) == sbtc_pkg::ADDR_IRQ_MASK
    |-> RDATA_OUT[4] == 1'b0) else $error("mask reserved bit set");
  read_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  stop_no_ovf_a: assert property (stop_age_q == 2'h3 && !$past(WR_IN) && $stable(GLOBAL_IRQ_EN_IN)
    |-> !$rose(IRQ_OVF_OUT)) else $error("overflow while stopped");
endmodule : sbtc_timer_monitor

// ---- bench/sbtc_timer_tb.sv ----
// sbtc_timer_tb: random and corner tests of the timer over its register port.
// assumes sbtc_pkg and the monitor compile first; seed 23 keeps runs repeatable.
`timescale 1ns/1ps
module sbtc_timer_tb;
  logic        clk, rst, wr, rd, cap, cmp, pin, gie, ack_o, ack_a, ack_b, ack_c;
  logic [7:0]  addr, wdata, rdata, d;
  logic        irq_o, irq_a, irq_b, irq_c, wave_a, wave_b;
  logic [15:0] r, v, cap_exp;
  int          err_count, samples_checked, k;
  sbtc_timer u_sbtc_timer (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .CAPTURE_INPUT_IN(cap), .COMPARATOR_IN(cmp), .COUNT_PIN_IN(pin),
    .GLOBAL_IRQ_EN_IN(gie), .ACK_OVF_IN(ack_o), .ACK_CMP_A_IN(ack_a), .ACK_CMP_B_IN(ack_b),
    .ACK_CAP_IN(ack_c), .IRQ_OVF_OUT(irq_o), .IRQ_CMP_A_OUT(irq_a), .IRQ_CMP_B_OUT(irq_b),
    .IRQ_CAP_OUT(irq_c), .WAVE_OUT_A_OUT(wave_a), .WAVE_OUT_B_OUT(wave_b));
  // ==========================================================
  // clock, bus tasks and compares
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // a idle cycle after each strobe keeps one assignment per time step
  task automatic wr8(input logic [7:0] a, input logic [7:0] x);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask : wr8
  task automatic rd8(input logic [7:0] a, output logic [7:0] x);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    #1;
    x = rdata;
    cyc(1);
  endtask : rd8
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr8(a + 8'h01, x[15:8]);
    wr8(a, x[7:0]);
  endtask : wr16
  task automatic rd16(input logic [7:0] a, output logic [15:0] x);
    rd8(a, x[7:0]);
    rd8(a + 8'h01, x[15:8]);
  endtask : rd16
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string s, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] g);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("Error %s expected %h..%h seen %h", s, lo, hi, g);
    end
  endtask : chk_rng
  function automatic int div_of(input logic [2:0] c);
    case (c)
      3'h2: return 8;
      3'h3: return 64;
      3'h4: return 256;
      3'h5: return 1024;
      default: return 1;
    endcase
  endfunction : div_of
  // counter gets a random start so each capture is told apart
  task automatic cap_try(input logic src, input logic lvl, input logic hit);
    logic [15:0] g;
    r = 16'($urandom);
    wr16(sbtc_pkg::ADDR_CNT_LO, r);
    if (src) cmp <= lvl;
    else cap <= lvl;
    cyc(12);
    if (hit) cap_exp = r;
    rd16(sbtc_pkg::ADDR_CAP_LO, g);
    chk("capture", cap_exp, g);
  endtask : cap_try
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(60000);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    print_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    {wr, rd, cap, cmp, pin, ack_o, ack_a, ack_b, ack_c} = '0;
    {addr, wdata} = '0;
    rst = 1'b1;
    gie = 1'b1;
    cap_exp = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(23));
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    rd8(sbtc_pkg::ADDR_CLK_CAP, d);
    chk("clock control reset", 16'h0000, 16'(d));
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'hF8);
    rd8(sbtc_pkg::ADDR_CLK_CAP, d);
    chk("clock control", 16'h00D8, 16'(d));
    wr8(sbtc_pkg::ADDR_IRQ_MASK, 8'hFF);
    rd8(sbtc_pkg::ADDR_IRQ_MASK, d);
    chk("mask", 16'(8'hFF & sbtc_pkg::MASK_IRQ_MASK), 16'(d));
    rd8(8'h00, d);
    chk("unmapped", 16'h0000, 16'(d));
    wr8(sbtc_pkg::ADDR_FORCE, 8'hC0);
    rd8(sbtc_pkg::ADDR_FORCE, d);
    chk("force read", 16'h0000, 16'(d));
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr16(sbtc_pkg::ADDR_CMP_A_LO, v);
      wr16(sbtc_pkg::ADDR_CNT_LO, ~v);
      rd16(sbtc_pkg::ADDR_CMP_A_LO, r);
      chk("compare A", v, r);
      rd16(sbtc_pkg::ADDR_CNT_LO, r);
      chk("counter", ~v, r);
    end
    $display("test sixteen bit done");
    wr8(sbtc_pkg::ADDR_WAVE_CTRL, 8'h70);
    wr8(sbtc_pkg::ADDR_IRQ_MASK, 8'h60);
    wr8(sbtc_pkg::ADDR_FLAGS, 8'hFF);
    wr8(sbtc_pkg::ADDR_FORCE, 8'hC0);
    cyc(2);
    chk("wave pair", 16'h0003, 16'({wave_a, wave_b}));
    chk("forced irq", 16'h0000, 16'({irq_a, irq_b}));
    wr8(sbtc_pkg::ADDR_WAVE_CTRL, 8'h71);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
    wr8(sbtc_pkg::ADDR_FORCE, 8'hC0);
    cyc(2);
    chk("pwm force", 16'h0001, 16'(wave_a));
    wr8(sbtc_pkg::ADDR_WAVE_CTRL, 8'hB0);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h08);
    wr16(sbtc_pkg::ADDR_CMP_A_LO, 16'h0008);
    wr16(sbtc_pkg::ADDR_CNT_LO, 16'h0008);
    wr8(sbtc_pkg::ADDR_FORCE, 8'h80);
    cyc(2);
    chk("ctc force wave", 16'h0000, 16'(wave_a));
    rd16(sbtc_pkg::ADDR_CNT_LO, r);
    chk("ctc force counter", 16'h0008, r);
    $display("test force done");
    wr16(sbtc_pkg::ADDR_CMP_A_LO, 16'h0010);
    wr16(sbtc_pkg::ADDR_CNT_LO, 16'h0000);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h09);
    cyc(40);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h08);
    chk("match irq A", 16'h0001, 16'(irq_a));
    rd16(sbtc_pkg::ADDR_CNT_LO, r);
    chk_rng("ctc counter", 16'h0000, 16'h0010, r);
    gie <= 1'b0;
    cyc(1);
    chk("gated irq A", 16'h0000, 16'(irq_a));
    gie <= 1'b1;
    ack_a <= 1'b1;
    cyc(1);
    ack_a <= 1'b0;
    cyc(1);
    chk("ack irq A", 16'h0000, 16'(irq_a));
    v = 16'($urandom_range(16'hFE00, 16'h0100));
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
    wr16(sbtc_pkg::ADDR_CMP_B_LO, v);
    wr16(sbtc_pkg::ADDR_CNT_LO, v + 16'h0100);
    wr8(sbtc_pkg::ADDR_FLAGS, 8'hFF);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h01);
    wr16(sbtc_pkg::ADDR_CNT_LO, v);
    cyc(3);
    chk("blocked match B", 16'h0000, 16'(irq_b));
    wr16(sbtc_pkg::ADDR_CNT_LO, v - 16'h0002);
    cyc(4);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
    chk("match irq B", 16'h0001, 16'(irq_b));
    wr8(sbtc_pkg::ADDR_IRQ_MASK, 8'h80);
    wr16(sbtc_pkg::ADDR_CNT_LO, 16'hFFFD);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h01);
    cyc(6);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
    chk("overflow irq", 16'h0001, 16'(irq_o));
    wr8(sbtc_pkg::ADDR_FLAGS, 8'h80);
    chk("overflow clear", 16'h0000, 16'(irq_o));
    $display("test compare done");
    for (int c = 1; c < 6; c++) begin
      k = 4 * div_of(3'(c));
      wr16(sbtc_pkg::ADDR_CNT_LO, 16'h0000);
      wr8(sbtc_pkg::ADDR_CLK_CAP, 8'(c));
      cyc(k);
      wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
      rd16(sbtc_pkg::ADDR_CNT_LO, r);
      v = 16'((k + 2) / div_of(3'(c)));
      chk_rng("prescaled count", v - 16'h0001, v + 16'h0001, r);
      cyc(30);
      rd16(sbtc_pkg::ADDR_CNT_LO, v);
      chk("stopped count", r, v);
    end
    for (int c = 6; c < 8; c++) begin
      wr16(sbtc_pkg::ADDR_CNT_LO, 16'h0000);
      wr8(sbtc_pkg::ADDR_CLK_CAP, 8'(c));
      repeat (5) begin
        pin <= 1'b1;
        cyc(3);
        pin <= 1'b0;
        cyc(3);
      end
      cyc(6);
      wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h00);
      rd16(sbtc_pkg::ADDR_CNT_LO, r);
      chk("pin count", 16'h0005, r);
    end
    $display("test clock select done");
    wr8(sbtc_pkg::ADDR_IRQ_MASK, 8'h08);
    wr8(sbtc_pkg::ADDR_FLAGS, 8'hFF);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'hC0);
    cap_try(1'b0, 1'b1, 1'b1);
    chk("capture irq", 16'h0001, 16'(irq_c));
    wr8(sbtc_pkg::ADDR_FLAGS, 8'h08);
    chk("capture clear", 16'h0000, 16'(irq_c));
    cap_try(1'b0, 1'b0, 1'b0);
    cap <= 1'b1;
    cyc(2);
    cap <= 1'b0;
    cyc(12);
    rd16(sbtc_pkg::ADDR_CAP_LO, r);
    chk("glitch", cap_exp, r);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h80);
    cap_try(1'b0, 1'b1, 1'b0);
    cap_try(1'b0, 1'b0, 1'b1);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'h98);
    cap_try(1'b0, 1'b1, 1'b0);
    cap_try(1'b0, 1'b0, 1'b0);
    wr8(sbtc_pkg::ADDR_CLK_CAP, 8'hC0);
    wr8(sbtc_pkg::ADDR_MISC, 8'h01);
    cap_try(1'b1, 1'b1, 1'b1);
    $display("test capture done");
    print_verdict();
  end
endmodule : sbtc_timer_tb
bind sbtc_timer sbtc_timer_monitor u_sbtc_timer_monitor (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN),
  .IRQ_OVF_OUT(IRQ_OVF_OUT), .IRQ_CMP_A_OUT(IRQ_CMP_A_OUT), .IRQ_CMP_B_OUT(IRQ_CMP_B_OUT));
